// ### smbus_block_pkg.sv
// constants shared by the smbus indexed block access target
// assumes a single clock generator configuration space of nine bytes
package smbus_block_pkg;

  // bus address per strap level (7-bit, without direction bit)
  localparam logic [6:0] ADDR_STRAP_LO = 7'h50;
  localparam logic [6:0] ADDR_STRAP_HI = 7'h52;

  // configuration byte indices
  localparam int NUM_BYTES = 9;
  localparam logic [7:0] IDX_OE = 8'h00;
  localparam logic [7:0] IDX_SS = 8'h01;
  localparam logic [7:0] IDX_SLEW = 8'h02;
  localparam logic [7:0] IDX_REF = 8'h03;
  localparam logic [7:0] IDX_REV = 8'h05;
  localparam logic [7:0] IDX_DEV = 8'h06;
  localparam logic [7:0] IDX_CNT = 8'h08;

  // reset values; revision and device codes are arbitrary
  localparam logic [7:0] RST_OE = 8'h0f;
  localparam logic [7:0] RST_SS = 8'h02;
  localparam logic [7:0] RST_SLEW = 8'h0f;
  localparam logic [7:0] RST_REF = 8'h5f;
  localparam logic [7:0] RST_REV = 8'h11;
  localparam logic [7:0] RST_DEV = 8'h22;
  localparam logic [7:0] RST_CNT = 8'h09;
  localparam logic [7:0] RST_ZERO = 8'h00;

  // writable bit masks; other bits are reserved or read-only
  localparam logic [7:0] WM_OE = 8'h0f;
  localparam logic [7:0] WM_SS = 8'h3b;
  localparam logic [7:0] WM_SLEW = 8'h0f;
  localparam logic [7:0] WM_REF = 8'hf0;
  localparam logic [7:0] WM_CNT = 8'h1f;
  localparam logic [7:0] WM_NONE = 8'h00;

  // field positions
  localparam int REF_SLEW_LSB = 6;
  localparam int REF_SLEW_W = 2;
  localparam int REF_WOL_BIT = 5;
  localparam int REF_OE_BIT = 4;
  localparam int LANE_W = 4;
  localparam int AMP_W = 2;
  localparam logic [3:0] REF_RSVD_ONES = 4'hf;

  // link state machine, one-hot
  typedef enum logic [10:0] {
    ST_IDLE      = 11'h001,
    ST_ADDR      = 11'h002,
    ST_ADDR_ACK  = 11'h004,
    ST_INDEX     = 11'h008,
    ST_INDEX_ACK = 11'h010,
    ST_COUNT     = 11'h020,
    ST_COUNT_ACK = 11'h040,
    ST_WDATA     = 11'h080,
    ST_WDATA_ACK = 11'h100,
    ST_TX        = 11'h200,
    ST_TX_ACK    = 11'h400
  } link_state_t;

endpackage : smbus_block_pkg

// ### smbus_host_model.sv
// smbus host model: owns the link clock and pulls the data line low
// assumes the bench resolves the open-drain line and feeds it back
`timescale 1ns/1ps
`default_nettype none

module smbus_host_model (
  input wire logic i_sda_line,
  output logic o_scl,
  output logic o_sda_low
);
  localparam time QTR = 16;

  // link clock stands high between frames, the line is released
  initial begin
    o_scl = 1'b1;
    o_sda_low = 1'b0;
  end

  // one 64 ns bit slot: data moves mid-low, sampled mid-high
  task automatic slot(input logic drive_low, output logic seen);
    #QTR o_sda_low = drive_low;
    #QTR o_scl = 1'b1;
    #QTR seen = i_sda_line;
    #QTR o_scl = 1'b0;
  endtask : slot

  // start and repeated start look alike on the wire
  task automatic start_cond;
    #QTR o_sda_low = 1'b0;
    #QTR o_scl = 1'b1;
    #QTR o_sda_low = 1'b1;
    #QTR o_scl = 1'b0;
  endtask : start_cond

  task automatic stop_cond;
    #QTR o_sda_low = 1'b1;
    #QTR o_scl = 1'b1;
    #QTR o_sda_low = 1'b0;
    #QTR;
  endtask : stop_cond

  // msb first, then the ninth slot left free for the device
  task automatic send_byte(input logic [7:0] b, output logic acked);
    logic seen;
    for (int i = 7; i >= 0; i--) slot(~b[i], seen);
    slot(1'b0, seen);
    acked = ~seen;
  endtask : send_byte

  task automatic recv_byte(input logic ack_it, output logic [7:0] b);
    logic seen;
    for (int i = 7; i >= 0; i--) begin
      slot(1'b0, seen);
      b[i] = seen;
    end
    slot(ack_it, seen);
  endtask : recv_byte
endmodule : smbus_host_model
`default_nettype wire

// ### smbus_indexed_block_access.sv
// smbus target giving indexed block access to the configuration bytes
// assumes scl arrives as the link clock and sda as separate in/out/enable pins
`timescale 1ns/1ps
`default_nettype none

module smbus_indexed_block_access (
  input wire logic i_sys_clk,
  input wire logic i_reset_n,
  input wire logic i_smb_clk,
  input wire logic i_sda_in,
  input wire logic i_address_strap_pin,
  output logic o_sda_out,
  output logic o_sda_oe_n,
  output logic [smbus_block_pkg::LANE_W-1:0] o_output_enable,
  output logic [smbus_block_pkg::LANE_W-1:0] o_dif_slew,
  output logic [smbus_block_pkg::AMP_W-1:0] o_amplitude,
  output logic [smbus_block_pkg::REF_SLEW_W-1:0] o_ref_slew,
  output logic o_ref_wol,
  output logic o_ref_oe
);
  import smbus_block_pkg::*;

  logic [1:0] rst_sync, strap_sync, strap_wait, strap_lk;
  logic rst_n, strap_done, strap_sel, start_tog, start_seen;
  link_state_t state, next_state;
  logic [2:0] bit_cnt, next_bit;
  logic rw, next_rw, wr_en, cfg_tog;
  logic [7:0] shift, index, next_index, wleft, next_wleft, tx_shift, next_tx;
  logic [7:0] cfg [NUM_BYTES];
  logic [2:0] tog_sys;

  function automatic logic [7:0] wmask(input logic [7:0] idx);
    case (idx)
      IDX_OE: wmask = WM_OE;
      IDX_SS: wmask = WM_SS;
      IDX_SLEW: wmask = WM_SLEW;
      IDX_REF: wmask = WM_REF;
      IDX_CNT: wmask = WM_CNT;
      default: wmask = WM_NONE;
    endcase
  endfunction : wmask
  function automatic logic [7:0] rst_val(input logic [7:0] idx);
    case (idx)
      IDX_OE: rst_val = RST_OE;
      IDX_SS: rst_val = RST_SS;
      IDX_SLEW: rst_val = RST_SLEW;
      IDX_REF: rst_val = RST_REF;
      IDX_REV: rst_val = RST_REV;
      IDX_DEV: rst_val = RST_DEV;
      IDX_CNT: rst_val = RST_CNT;
      default: rst_val = RST_ZERO;
    endcase
  endfunction : rst_val
  // bytes past the last index read as zero
  function automatic logic [7:0] rd_byte(input logic [7:0] idx);
    rd_byte = (idx < 8'(NUM_BYTES)) ? cfg[idx[3:0]] : RST_ZERO;
  endfunction : rd_byte
  // reset release through two flops on the system clock
  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) rst_sync <= 2'h0;
    else rst_sync <= {rst_sync[0], 1'b1};
  end
  assign rst_n = rst_sync[1];
  // strap caught once, after the synchroniser has filled, then frozen
  always_ff @(posedge i_sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      strap_sync <= 2'h0;
      strap_wait <= 2'h0;
      strap_done <= 1'b0;
      strap_sel <= 1'b0;
    end else begin
      strap_sync <= {strap_sync[0], i_address_strap_pin};
      strap_wait <= {strap_wait[0], 1'b1};
      if (strap_wait[1] && !strap_done) begin
        strap_sel <= strap_sync[1];
        strap_done <= 1'b1;
      end
    end
  end

  // latched strap level into the link domain; static after latch
  always_ff @(posedge i_smb_clk or negedge rst_n) begin
    if (!rst_n) strap_lk <= 2'h0;
    else strap_lk <= {strap_lk[0], strap_sel};
  end

  wire [6:0] my_addr = strap_lk[1] ? ADDR_STRAP_HI : ADDR_STRAP_LO;
  // start condition: sda falls while scl is high; a toggle so it needs no clear
  always_ff @(negedge i_sda_in or negedge rst_n) begin
    if (!rst_n) start_tog <= 1'b0;
    else if (i_smb_clk) start_tog <= ~start_tog;
  end

  // decoding of the received byte and the state under way
  wire [7:0] byte_in = {shift[6:0], i_sda_in};
  wire byte_done = (bit_cnt == 3'h7);
  wire start_pend = (start_tog != start_seen);
  wire addr_hit = (byte_in[7:1] == my_addr);
  wire [7:0] rd_now = rd_byte(index);
  wire in_ack = (state == ST_ADDR_ACK) || (state == ST_INDEX_ACK) || (state == ST_COUNT_ACK) ||
                (state == ST_WDATA_ACK);
  wire drive_low = in_ack || ((state == ST_TX) && !tx_shift[7]);

  // next-state logic, evaluated at each rising scl
  always_comb begin
    next_state = state;
    next_bit = bit_cnt + 3'h1;
    next_rw = rw;
    next_index = index;
    next_wleft = wleft;
    next_tx = {tx_shift[6:0], 1'b0};
    wr_en = 1'b0;
    if (start_pend) begin
      // repeated start restarts at the address wherever we were
      next_state = ST_ADDR;
      next_bit = 3'h1;
    end else begin
      case (state)
        ST_ADDR: if (byte_done) begin
          next_rw = byte_in[0];
          next_state = addr_hit ? ST_ADDR_ACK : ST_IDLE;
        end
        ST_ADDR_ACK: begin
          next_bit = 3'h0;
          if (rw) begin
            next_state = ST_TX;
            next_tx = rd_byte(IDX_CNT);
          end else begin
            next_state = ST_INDEX;
          end
        end
        ST_INDEX: if (byte_done) begin
          next_index = byte_in;
          next_state = ST_INDEX_ACK;
        end
        ST_INDEX_ACK: begin
          next_bit = 3'h0;
          next_state = ST_COUNT;
        end
        ST_COUNT: if (byte_done) begin
          next_wleft = byte_in;
          next_state = ST_COUNT_ACK;
        end
        ST_COUNT_ACK: begin
          next_bit = 3'h0;
          next_state = ST_WDATA;
        end
        ST_WDATA: if (byte_done) begin
          // bytes beyond the announced count are refused
          wr_en = (wleft != 8'h00);
          next_state = (wleft != 8'h00) ? ST_WDATA_ACK : ST_IDLE;
        end
        ST_WDATA_ACK: begin
          next_bit = 3'h0;
          next_index = index + 8'h01;
          next_wleft = wleft - 8'h01;
          next_state = ST_WDATA;
        end
        ST_TX: if (byte_done) next_state = ST_TX_ACK;
        ST_TX_ACK: begin
          next_bit = 3'h0;
          if (!i_sda_in) begin
            next_state = ST_TX;
            next_tx = rd_now;
            next_index = index + 8'h01;
          end else next_state = ST_IDLE; // not-acknowledge ends the read
        end
        ST_IDLE: next_bit = 3'h0;
        default: next_state = ST_IDLE;
      endcase
    end
  end

  // link state registers on rising scl
  always_ff @(posedge i_smb_clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= ST_IDLE;
      bit_cnt <= 3'h0;
      shift <= 8'h00;
      rw <= 1'b0;
      index <= 8'h00;
      wleft <= 8'h00;
      tx_shift <= 8'h00;
      start_seen <= 1'b0;
    end else begin
      state <= next_state;
      bit_cnt <= next_bit;
      shift <= byte_in;
      rw <= next_rw;
      index <= next_index;
      wleft <= next_wleft;
      tx_shift <= next_tx;
      start_seen <= start_tog;
    end
  end

  // configuration bytes live in the link domain so reads need no crossing
  always_ff @(posedge i_smb_clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < NUM_BYTES; i++) cfg[i] <= rst_val(8'(i));
      cfg_tog <= 1'b0;
    end else if (wr_en && (index < 8'(NUM_BYTES))) begin
      cfg[index[3:0]] <= (cfg[index[3:0]] & ~wmask(index)) | (byte_in & wmask(index));
      cfg_tog <= ~cfg_tog;
    end
  end

  // sda changes only while scl is low, hence the falling edge
  always_ff @(negedge i_smb_clk or negedge rst_n) begin
    if (!rst_n) begin
      o_sda_oe_n <= 1'b1;
      o_sda_out <= 1'b0;
    end else begin
      o_sda_oe_n <= ~drive_low;
      o_sda_out <= 1'b0;
    end
  end

  // update toggle crossed into the system domain; a byte takes nine scl periods,
  // so the bytes are long stable when the copy is taken
  always_ff @(posedge i_sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      tog_sys <= 3'h0;
      o_output_enable <= RST_OE[LANE_W-1:0];
      o_dif_slew <= RST_SLEW[LANE_W-1:0];
      o_amplitude <= RST_SS[AMP_W-1:0];
      o_ref_slew <= RST_REF[REF_SLEW_LSB +: REF_SLEW_W];
      o_ref_wol <= RST_REF[REF_WOL_BIT];
      o_ref_oe <= RST_REF[REF_OE_BIT];
    end else begin
      tog_sys <= {tog_sys[1:0], cfg_tog};
      if (tog_sys[2] != tog_sys[1]) begin
        o_output_enable <= cfg[IDX_OE[3:0]][LANE_W-1:0];
        o_dif_slew <= cfg[IDX_SLEW[3:0]][LANE_W-1:0];
        o_amplitude <= cfg[IDX_SS[3:0]][AMP_W-1:0];
        o_ref_slew <= cfg[IDX_REF[3:0]][REF_SLEW_LSB +: REF_SLEW_W];
        o_ref_wol <= cfg[IDX_REF[3:0]][REF_WOL_BIT];
        o_ref_oe <= cfg[IDX_REF[3:0]][REF_OE_BIT];
      end
    end
  end

  AST_FOREIGN_IGNORED: assert property (@(posedge i_smb_clk) disable iff (!rst_n)
    (state == ST_ADDR && byte_done && !addr_hit && !start_pend) |=> (state == ST_IDLE) ##1 o_sda_oe_n)
    else $error("foreign address was not ignored");
  AST_INDEX_ACKED: assert property (@(posedge i_smb_clk) disable iff (!rst_n)
    (state == ST_INDEX && byte_done && !start_pend) |=> (state == ST_INDEX_ACK) && !o_sda_oe_n)
    else $error("index byte not acknowledged");
  AST_COUNT_ACKED: assert property (@(posedge i_smb_clk) disable iff (!rst_n)
    (state == ST_COUNT && byte_done && !start_pend) |=> (state == ST_COUNT_ACK) && !o_sda_oe_n)
    else $error("count byte not acknowledged");
  AST_DATA_STORED: assert property (@(posedge i_smb_clk) disable iff (!rst_n)
    (state == ST_WDATA && byte_done && wleft != 8'h00 && index == IDX_OE && !start_pend)
    |=> cfg[0] == (($past(cfg[0]) & ~WM_OE) | ($past(byte_in) & WM_OE)))
    else $error("data byte not stored at its index");
  AST_COUNT_FIRST: assert property (@(posedge i_smb_clk) disable iff (!rst_n)
    (state == ST_ADDR_ACK && rw && !start_pend) |=> (state == ST_TX) && (tx_shift == cfg[8]))
    else $error("read did not begin with the count byte");

  AST_NEXT_INDEX: assert property (@(posedge i_smb_clk) disable iff (!rst_n)
    (state == ST_TX_ACK && !i_sda_in && !start_pend)
    |=> (tx_shift == $past(rd_now)) && (index == $past(index) + 8'h01))
    else $error("read bytes not in increasing index order");

  AST_BYTE_EIGHT_BITS: assert property (@(posedge i_smb_clk) disable iff (!rst_n)
    (state == ST_TX_ACK && !i_sda_in && !start_pend) |=> (state == ST_TX) [*8] ##1 (state == ST_TX_ACK || start_pend))
    else $error("transmitted byte not eight bits long");

  AST_REF_RESERVED: assert property (@(posedge i_smb_clk) disable iff (!rst_n)
    cfg[3][3:0] == REF_RSVD_ONES)
    else $error("reference control reserved bits changed");

  AST_STRAP_FROZEN: assert property (@(posedge i_sys_clk) disable iff (!rst_n)
    strap_done |=> $stable(strap_sel) && strap_done)
    else $error("latched strap level moved");

endmodule : smbus_indexed_block_access

`default_nettype wire

// ### smbus_indexed_block_access_tb_top.sv
// bench for the smbus indexed block access target
// assumes the host model owns the link clock; the line has a pull-up
`timescale 1ns/1ps
`default_nettype none

module smbus_indexed_block_access_tb_top;
  import smbus_block_pkg::*;
  typedef struct packed {logic [7:0] idx; logic [7:0] dat;} row_t;
  logic sys_clk = 1'b0;
  logic reset_n = 1'b0;
  logic strap = 1'b1;
  logic scl, host_low, sda_out, sda_oe_n, ref_wol, ref_oe;
  logic [3:0] oe, dif_slew;
  logic [1:0] amp, ref_slew;
  int mismatches = 0;
  int checks_done = 0;
  logic [7:0] m [9];
  logic [7:0] rv [9] = '{RST_OE, RST_SS, RST_SLEW, RST_REF, RST_ZERO, RST_REV, RST_DEV, RST_ZERO, RST_CNT};
  logic [7:0] wm [9] = '{WM_OE, WM_SS, WM_SLEW, WM_REF, WM_NONE, WM_NONE, WM_NONE, WM_NONE, WM_CNT};
  row_t rows [10] = '{'{8'h00, 8'ha5}, '{8'h02, 8'h3c}, '{8'h03, 8'h1f}, '{8'h03, 8'h9f}, '{8'h03, 8'hdf},
    '{8'h03, 8'h5f}, '{8'h01, 8'h03}, '{8'h05, 8'hff}, '{8'h06, 8'h00}, '{8'h03, 8'h20}};
  // either party pulling low wins over the pull-up
  wire logic sda_line = ~((~sda_oe_n & ~sda_out) | host_low);

  always #12.5 sys_clk = ~sys_clk;

  smbus_indexed_block_access DUT (.i_sys_clk(sys_clk), .i_reset_n(reset_n), .i_smb_clk(scl),
    .i_sda_in(sda_line), .i_address_strap_pin(strap), .o_sda_out(sda_out), .o_sda_oe_n(sda_oe_n),
    .o_output_enable(oe), .o_dif_slew(dif_slew), .o_amplitude(amp), .o_ref_slew(ref_slew),
    .o_ref_wol(ref_wol), .o_ref_oe(ref_oe));
  smbus_host_model host (.i_sda_line(sda_line), .o_scl(scl), .o_sda_low(host_low));

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : tally_and_finish

  task automatic cmp(input string what, input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask : cmp

  task automatic put(input logic [7:0] b, input logic exp_ack, input string what);
    logic a;
    host.send_byte(b, a);
    cmp(what, {7'h00, a}, {7'h00, exp_ack});
  endtask : put

  task automatic head(input logic [6:0] adr, input logic [7:0] n, input logic ok);
    host.start_cond();
    put({adr, 1'b0}, ok, "address ack");
    if (ok) put(n, 1'b1, "index ack");
  endtask : head

  // the model byte only moves where the write mask lets it
  task automatic blk_write(input logic [6:0] adr, input logic [7:0] n, input int cnt, input logic [7:0] d[$]);
    head(adr, n, 1'b1);
    put(8'(cnt), 1'b1, "count ack");
    foreach (d[k]) begin
      put(d[k], k < cnt, "data ack");
      if (k < cnt && n + k < 9) m[n+k] = (m[n+k] & ~wm[n+k]) | (d[k] & wm[n+k]);
    end
    host.stop_cond();
  endtask : blk_write

  // every byte, read-only bits included, must match the model exactly
  task automatic blk_read(input logic [6:0] adr, input logic [7:0] n, input int nb);
    logic [7:0] b;
    head(adr, n, 1'b1);
    host.start_cond();
    put({adr, 1'b1}, 1'b1, "read address ack");
    host.recv_byte(1'b1, b);
    cmp("count byte", b, m[8]);
    for (int k = 0; k < nb; k++) begin
      host.recv_byte(k < nb - 1, b);
      cmp("read byte", b, m[n+k]);
    end
    host.stop_cond();
  endtask : blk_read

  task automatic chk_out;
    repeat (8) @(posedge sys_clk);
    @(negedge sys_clk);
    cmp("output enable", {4'h0, oe}, {4'h0, m[0][3:0]});
    cmp("dif slew", {4'h0, dif_slew}, {4'h0, m[2][3:0]});
    cmp("amplitude", {6'h00, amp}, {6'h00, m[1][1:0]});
    cmp("ref control", {4'h0, ref_slew, ref_wol, ref_oe}, {4'h0, m[3][7:4]});
  endtask : chk_out

  // the foreign frame also gives the link side its first clock edges
  task automatic do_reset;
    reset_n <= 1'b0;
    repeat (5) @(posedge sys_clk);
    reset_n <= 1'b1;
    repeat (60) @(posedge sys_clk);
    m = rv;
    head(7'h51, 8'h00, 1'b0);
    host.stop_cond();
    chk_out();
  endtask : do_reset

  initial begin
    @(posedge sys_clk);
    do_reset();
    @(posedge sys_clk);
    strap <= 1'b0;
    blk_read(ADDR_STRAP_HI, 8'h00, 9);
    foreach (rows[r]) begin
      blk_write(ADDR_STRAP_HI, rows[r].idx, 1, {rows[r].dat});
      chk_out();
      blk_read(ADDR_STRAP_HI, rows[r].idx, 1);
    end
    // back to back bytes, a byte past the count, then a shorter count
    blk_write(ADDR_STRAP_HI, 8'h00, 3, {8'h0a, 8'h05, 8'h33});
    blk_read(ADDR_STRAP_HI, 8'h00, 3);
    blk_write(ADDR_STRAP_HI, 8'h02, 1, {8'h06, 8'h09});
    blk_write(ADDR_STRAP_HI, IDX_CNT, 1, {8'he3});
    blk_read(ADDR_STRAP_HI, 8'h01, 3);
    head(ADDR_STRAP_LO, 8'h00, 1'b0);
    host.stop_cond();
    @(posedge sys_clk);
    do_reset();
    blk_read(ADDR_STRAP_LO, 8'h00, 9);
    tally_and_finish();
  end

  // watchdog against a hung run
  initial begin
    repeat (100000) @(posedge sys_clk);
    mismatches++;
    tally_and_finish();
  end
endmodule : smbus_indexed_block_access_tb_top
`default_nettype wire
